// ===== odac_top.v
// two-wire target with buffered/active channel codes, load strobe, clear and power-down
// assumes scl, sda and the pins come from outside the clk domain; bus wire resolved outside
`timescale 1ns/1ps
`include "odac_defines.vh"
module odac_top #(
  parameter CODE_W = 10,
  parameter [5:0] DEVICE_ID = 6'h2a // arbitrary value
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  input wire address_select_pin,
  input wire load_strobe_n,
  input wire clear_outputs_n,
  output reg [8*CODE_W-1:0] channel_code_q,
  output reg [7:0] power_down_q
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_TX = 3'd3;
  localparam ST_MACK = 3'd4;
  localparam ST_SKIP = 3'd5;

  // pins: scl, sda, select, strobe, clear
  wire [4:0] pins_s;
  wire scl_s;
  wire sda_s;
  wire a0_s;
  wire ld_s;
  // clear acts asynchronously on the buffer and active code registers; never glitch-filtered
  wire arst;
  wire [8*CODE_W-1:0] buf_words;

  reg scl_p_q;
  reg sda_p_q;
  reg ld_p_q;
  reg [2:0] state_q;
  reg [3:0] bitcnt_q;
  reg [1:0] idx_q;
  reg [7:0] sh_q;
  reg [7:0] tx_q;
  reg tx_lo_q;
  reg rw_q;
  reg gc_q;
  reg gc_arm_q;
  reg commit_arm_q;
  reg commit_q;
  reg soft_rst_q;
  reg [7:0] cmd_q;
  reg [7:0] msb_q;
  reg [7:0] lsb_q;
  reg async_mode_q;
  reg a0_lo_q;
  reg a0_hi_q;
  reg a0_ne_sda_q;
  reg a0_ne_scl_q;
  reg [8:0] cfg_q;
  reg [7:0] pending_q;

  reg [2:0] a0_sel;
  reg addr_hit;
  reg [15:0] rd_word;
  reg wr_chan;
  reg wr_bcast;

  integer i;

  assign arst = rst | ~clear_outputs_n; // R6
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign a0_s = pins_s[2];
  assign ld_s = pins_s[3];

  wire scl_rise = scl_s & ~scl_p_q; // R21
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire ld_fall = ld_p_q & ~ld_s;

  // strobe and clear levels pass four flops; clear copy here only feeds the pin map
  odac_sync3 #(
    .W(5),
    .RST_VAL(5'h1b)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din({clear_outputs_n, load_strobe_n, address_select_pin, sda_in, scl_in}),
    .dout_q(pins_s)
  ); // R26

  // code field sits left aligned under the upper data bits
  function [CODE_W-1:0] code_of;
    input [15:0] d;
    reg [15:0] t;
    begin
      t = d >> (`ODAC_CODE_MSB + 1 - CODE_W);
      code_of = t[CODE_W-1:0]; // R1
    end
  endfunction

  function [15:0] word_of;
    input [CODE_W-1:0] c;
    reg [15:0] t;
    begin
      t = {{(16 - CODE_W){1'b0}}, c};
      word_of = t << (`ODAC_CODE_MSB + 1 - CODE_W);
    end
  endfunction

  // select pin may be tied low, high, to sda or to scl
  always @* begin
    if (!a0_hi_q) begin
      a0_sel = 3'h0;
    end else if (!a0_lo_q) begin
      a0_sel = 3'h1;
    end else if (!a0_ne_sda_q) begin
      a0_sel = 3'h2;
    end else if (!a0_ne_scl_q) begin
      a0_sel = 3'h3;
    end else begin
      // pin matched no legal tie; fall back to the ground address
      a0_sel = 3'h0;
    end
  end

  always @* begin
    addr_hit = 1'b0;
    if (sh_q[7:1] == {`ODAC_ADDR_UPPER, a0_sel}) begin
      addr_hit = 1'b1; // R15 R24
    end else if (sh_q[7:1] == `ODAC_BCAST_ADDR && !sh_q[0]) begin
      addr_hit = 1'b1; // R25
    end else if (sh_q == `ODAC_GC_ADDR) begin
      addr_hit = 1'b1; // R16
    end
  end

  always @* begin
    rd_word = 16'h0000;
    if (cmd_q == `ODAC_CMD_CONFIG) begin
      rd_word = {7'h00, cfg_q};
    end else if (cmd_q == `ODAC_CMD_TRIGGER) begin
      rd_word = {4'h0, DEVICE_ID, 6'h00};
    end else if (cmd_q[7:3] == `ODAC_CMD_CHAN_HI) begin
      rd_word = word_of(buf_words[cmd_q[2:0]*CODE_W +: CODE_W]);
    end
  end

  always @* begin
    wr_chan = commit_q && !gc_q && (cmd_q[7:3] == `ODAC_CMD_CHAN_HI);
    wr_bcast = commit_q && !gc_q && (cmd_q == `ODAC_CMD_BCAST);
  end

  // bus target engine
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ld_p_q <= 1'b1;
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      idx_q <= 2'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      tx_lo_q <= 1'b0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      gc_arm_q <= 1'b0;
      commit_arm_q <= 1'b0;
      commit_q <= 1'b0;
      soft_rst_q <= 1'b0;
      cmd_q <= 8'h00;
      msb_q <= 8'h00;
      lsb_q <= 8'h00;
      async_mode_q <= 1'b0;
      a0_lo_q <= 1'b0;
      a0_hi_q <= 1'b0;
      a0_ne_sda_q <= 1'b0;
      a0_ne_scl_q <= 1'b0;
      sda_out_q <= 1'b0; // R20
      sda_oe_q <= 1'b0;
    end else if (ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      ld_p_q <= ld_s;
      commit_q <= 1'b0;
      soft_rst_q <= 1'b0;
      if (commit_q && !gc_q && cmd_q == `ODAC_CMD_TRIGGER &&
          lsb_q[`ODAC_SWRST_LSB +: 4] == `ODAC_SWRST_CODE) begin
        soft_rst_q <= 1'b1; // R9
      end
      if (state_q == ST_RX && idx_q == 2'h0) begin
        a0_lo_q <= a0_lo_q | ~a0_s;
        a0_hi_q <= a0_hi_q | a0_s;
        a0_ne_sda_q <= a0_ne_sda_q | (a0_s ^ sda_s);
        a0_ne_scl_q <= a0_ne_scl_q | (a0_s ^ scl_s);
      end
      if (start_c) begin
        state_q <= ST_RX; // R13
        bitcnt_q <= 4'h0;
        idx_q <= 2'h0;
        gc_q <= 1'b0;
        gc_arm_q <= 1'b0;
        commit_arm_q <= 1'b0;
        sda_oe_q <= 1'b0;
        async_mode_q <= ~ld_s; // R4 R5
        a0_lo_q <= 1'b0;
        a0_hi_q <= 1'b0;
        a0_ne_sda_q <= 1'b0;
        a0_ne_scl_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && bitcnt_q == 4'h8) begin
              bitcnt_q <= 4'h0;
              state_q <= ST_ACK;
              sda_oe_q <= 1'b1; // R18
              if (idx_q == 2'h0) begin
                if (addr_hit) begin
                  rw_q <= sh_q[0]; // R14
                  gc_q <= (sh_q == `ODAC_GC_ADDR);
                end else begin
                  state_q <= ST_SKIP; // R12 R19
                  sda_oe_q <= 1'b0;
                end
              end else if (gc_q) begin
                gc_arm_q <= (idx_q == 2'h1) && (sh_q == `ODAC_GC_RESET); // R16
              end else if (idx_q == 2'h1) begin
                cmd_q <= sh_q; // R22
              end else if (idx_q == 2'h2) begin
                msb_q <= sh_q;
              end else begin
                lsb_q <= sh_q;
                commit_arm_q <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_rise && gc_arm_q) begin
              soft_rst_q <= 1'b1; // R17
              gc_arm_q <= 1'b0;
            end else if (scl_fall) begin
              commit_q <= commit_arm_q; // R23
              commit_arm_q <= 1'b0;
              if (idx_q == 2'h0 && rw_q) begin
                state_q <= ST_TX; // R14
                tx_q <= rd_word[15:8];
                tx_lo_q <= 1'b1;
                sda_oe_q <= ~rd_word[15];
              end else begin
                state_q <= ST_RX;
                sda_oe_q <= 1'b0;
              end
              idx_q <= (idx_q == 2'h3) ? 2'h2 : idx_q + 2'h1;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bitcnt_q <= bitcnt_q + 4'h1;
              if (bitcnt_q == 4'h7) begin
                state_q <= ST_MACK;
                bitcnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_q <= ~tx_q[6]; // R20
              end
            end
          end
          ST_MACK: begin
            if (scl_rise && sda_s) begin
              state_q <= ST_SKIP; // R19
            end else if (scl_fall) begin
              state_q <= ST_TX;
              tx_q <= tx_lo_q ? rd_word[7:0] : rd_word[15:8];
              sda_oe_q <= tx_lo_q ? ~rd_word[7] : ~rd_word[15];
              tx_lo_q <= ~tx_lo_q;
            end
          end
          ST_SKIP: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  odac_buf_mem #(
    .CODE_W(CODE_W),
    .NCH(8)
  ) u_buf (
    .clk(clk),
    .arst(arst),
    .ce(ce),
    .sclr(soft_rst_q),
    .wr_en(wr_chan | wr_bcast),
    .wr_all(wr_bcast),
    .wr_idx(cmd_q[2:0]),
    .wr_data(code_of({msb_q, lsb_q})),
    .words_q(buf_words)
  ); // R3

  // configuration: power-down bits, reset to all channels down
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `ODAC_CONFIG_RST; // R11
      power_down_q <= 8'hff;
    end else if (ce) begin
      if (soft_rst_q) begin
        cfg_q <= `ODAC_CONFIG_RST; // R9 R11
      end else if (commit_q && !gc_q && cmd_q == `ODAC_CMD_CONFIG) begin
        cfg_q <= {msb_q[0], lsb_q};
      end
      power_down_q <= cfg_q[7:0] | {8{cfg_q[`ODAC_PD_ALL_BIT]}}; // R10
    end
  end

  // active codes: immediate write of the bus data or strobe-gated copy from the buffers
  always @(posedge clk or posedge arst) begin
    if (arst) begin
      channel_code_q <= {8*CODE_W{1'b0}}; // R2 R6
      pending_q <= 8'h00;
    end else if (ce) begin
      if (soft_rst_q) begin
        channel_code_q <= {8*CODE_W{1'b0}}; // R2
        pending_q <= 8'h00;
      end else begin
        for (i = 0; i < 8; i = i + 1) begin
          if (ld_fall && pending_q[i]) begin
            channel_code_q[i*CODE_W +: CODE_W] <= buf_words[i*CODE_W +: CODE_W]; // R5
            pending_q[i] <= 1'b0;
          end
          if (wr_bcast || (wr_chan && cmd_q[2:0] == i[2:0])) begin
            if (async_mode_q) begin
              channel_code_q[i*CODE_W +: CODE_W] <= code_of({msb_q, lsb_q}); // R4 R8
            end else begin
              pending_q[i] <= 1'b1; // R5
            end
          end
        end
      end
    end
  end
endmodule // odac_top

// ===== odac_defines.vh
// register offsets, field layout, bus codes and reset values of the octal converter control
// assumes inclusion by odac_top and its helpers only
//
// Behaviour
// (R1) codes are straight binary, 10 or 8 bits
// (R2) any reset leaves all channel codes zero
// (R3) bus writes land in buffer before active
// (R4) strobe low at frame start: update at once
// (R5) strobe high: hold until strobe falls, together
// (R6) clear low forces buffers and actives zero
// (R7) master waits 5 ms after power-up
// (R8) outputs hold until a channel is written
// (R9) soft reset code in trigger register resets
// (R10) outputs powered down singly or all together
// (R11) power-down bits start set after reset
// (R12) device is only a bus target
// (R13) master makes clock, start, stop, addressing
// (R14) receive on writes, transmit on reads
// (R15) only 7-bit target addresses decoded
// (R16) general call 0x00 then 0x06 resets
// (R17) general call reset at ack rising edge
// (R18) receiver acks by holding data low
// (R19) data left high means not-acknowledge
// (R20) bus lines driven open-drain only
// (R21) same protocol at all three bus rates
// (R22) frame: address, command, upper, lower bytes
// (R23) write takes effect at final ack fall
// (R24) address 1001 plus three select bits
// (R25) broadcast address accepted for writes only
// (R26) strobe and clear synchronised before use; clear here resets codes and buffers straight from the pin, unsynchronised
`ifndef ODAC_DEFINES_VH
`define ODAC_DEFINES_VH

`define ODAC_CMD_CONFIG 8'h01
`define ODAC_CMD_TRIGGER 8'h02
`define ODAC_CMD_BCAST 8'h03
`define ODAC_CMD_CHAN_HI 5'h01
`define ODAC_ADDR_UPPER 4'h9
`define ODAC_BCAST_ADDR 7'h47
`define ODAC_GC_ADDR 8'h00
`define ODAC_GC_RESET 8'h06
`define ODAC_SWRST_CODE 4'ha
`define ODAC_SWRST_LSB 0
`define ODAC_ID_LSB 6
`define ODAC_PD_ALL_BIT 8
`define ODAC_CONFIG_RST 9'h0ff
`define ODAC_CODE_MSB 11

`endif

// ===== odac_sync3.v
// three-stage input synchroniser with agreement filter
// assumes asynchronous inputs; output changes only when stages two and three agree
`timescale 1ns/1ps
module odac_sync3 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] din,
  output reg [W-1:0] dout_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      dout_q <= RST_VAL;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout_q <= (s2_q & s3_q) | (dout_q & (s2_q | s3_q));
    end
  end
endmodule // odac_sync3

// ===== odac_buf_mem.v
// per-channel buffer registers, all words visible at once for the simultaneous update
// assumes arst already combines device reset and the clear pin
`timescale 1ns/1ps
module odac_buf_mem #(
  parameter CODE_W = 10,
  parameter NCH = 8
) (
  input wire clk,
  input wire arst,
  input wire ce,
  input wire sclr,
  input wire wr_en,
  input wire wr_all,
  input wire [2:0] wr_idx,
  input wire [CODE_W-1:0] wr_data,
  output reg [NCH*CODE_W-1:0] words_q
);
  integer i;

  always @(posedge clk or posedge arst) begin
    if (arst) begin
      words_q <= {NCH*CODE_W{1'b0}}; // R2 R6
    end else if (ce) begin
      if (sclr) begin
        words_q <= {NCH*CODE_W{1'b0}}; // R2
      end else if (wr_en) begin
        for (i = 0; i < NCH; i = i + 1) begin
          if (wr_all || (wr_idx == i[2:0])) begin
            words_q[i*CODE_W +: CODE_W] <= wr_data; // R3
          end
        end
      end
    end
  end
endmodule // odac_buf_mem

// ===== odac_chk_assertions.sv
// port-level checker for odac_top
// assumes one clk domain; bound to every odac_top below
`timescale 1ns/1ps
module odac_chk #(
  parameter CODE_W = 10,
  parameter [5:0] DEVICE_ID = 6'h2a
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_q,
  input wire address_select_pin,
  input wire load_strobe_n,
  input wire clear_outputs_n,
  input wire [8*CODE_W-1:0] channel_code_q,
  input wire [7:0] power_down_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_sda_low_only: assert property (sda_out_q == 1'b0)
    else $error("sda output value not low");
  a_reset_values: assert property ($fell(rst) |->
    channel_code_q == '0 && power_down_q == 8'hff) else $error("bad values after reset");
  a_clear_zero: assert property (!clear_outputs_n |-> channel_code_q == '0)
    else $error("codes not zero under clear");
  a_clear_keeps_pd: assert property (!clear_outputs_n |=> $stable(power_down_q))
    else $error("clear touched power-down");
  a_code_quiet: assert property (($stable(scl_in) && load_strobe_n)[*8] |=>
    $stable(channel_code_q) || !clear_outputs_n) else $error("code moved without cause");
  a_pd_quiet: assert property ($stable(scl_in)[*8] |=> $stable(power_down_q))
    else $error("power-down moved without bus");
  a_oe_scl_low: assert property ($changed(sda_oe_q) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_oe_steady_high: assert property ($rose(scl_in) |=> $stable(sda_oe_q)[*8])
    else $error("sda drive not held over scl high");
  cover property ($fell(load_strobe_n));
  cover property ($rose(sda_oe_q));
  cover property ($changed(channel_code_q));
endmodule // odac_chk

bind odac_top odac_chk #(.CODE_W(CODE_W), .DEVICE_ID(DEVICE_ID)) chk_u (
  .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .address_select_pin(address_select_pin),
  .load_strobe_n(load_strobe_n), .clear_outputs_n(clear_outputs_n),
  .channel_code_q(channel_code_q), .power_down_q(power_down_q));

// ===== odac_bus_master.sv
// two-wire bus master model, 160 ns bus clock
// assumes pull-ups; sda_oe high means the target pulls sda low
`timescale 1ns/1ps
module odac_bus_master (
  input wire clk,
  input wire sda_oe,
  output wire scl,
  output wire sda
);
  reg scl_q = 1'b1;
  reg pull_q = 1'b0;
  assign scl = scl_q;
  assign sda = ~(pull_q | sda_oe);
  // start one step after a clk edge so no bus change races the target's sampling
  task start;
    begin
      @(posedge clk);
      #1 pull_q = 1'b1;
      #80 scl_q = 1'b0;
    end
  endtask
  task stop;
    begin
      #40 pull_q = 1'b1;
      #40 scl_q = 1'b1;
      #80 pull_q = 1'b0;
      #80;
    end
  endtask
  // data moves mid-low, sampled mid-high
  task bit_io(input b, output s);
    begin
      #40 pull_q = ~b;
      #40 scl_q = 1'b1;
      #40 s = sda;
      #40 scl_q = 1'b0;
    end
  endtask
  task wbyte(input [7:0] b, output ack);
    reg s;
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) bit_io(b[k], s);
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask
  task rbyte(input last, output [7:0] d);
    reg s;
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) bit_io(1'b1, d[k]);
      bit_io(last, s);
    end
  endtask
  task frame(input [6:0] a, input [7:0] c, input [15:0] w, output ok);
    reg k0, k1, k2, k3;
    begin
      start;
      wbyte({a, 1'b0}, k0);
      wbyte(c, k1);
      wbyte(w[15:8], k2);
      wbyte(w[7:0], k3);
      stop;
      ok = k0 & k1 & k2 & k3;
    end
  endtask
  task rd16(input [6:0] a, output [15:0] w, output ok);
    begin
      start;
      wbyte({a, 1'b1}, ok);
      rbyte(1'b0, w[15:8]);
      rbyte(1'b1, w[7:0]);
      stop;
    end
  endtask
endmodule // odac_bus_master

// ===== octal_dac_update_control_bench.sv
// self-checking bench for odac_top
// assumes odac_bus_master as the far side of the bus
`timescale 1ns/1ps
module octal_dac_update_control_bench;
  localparam W = 10;
  localparam [5:0] ID = 6'h15; // arbitrary value
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg strobe_n = 1'b0;
  reg clr_n = 1'b1;
  reg sel = 1'b0;
  reg ack;
  reg [15:0] rd;
  reg [15:0] w;
  wire scl, sda, sda_out, sda_oe;
  wire [8*W-1:0] codes;
  wire [7:0] pd;
  integer failures = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  integer i;
  initial forever #5 clk = ~clk;
  odac_top #(.CODE_W(W), .DEVICE_ID(ID)) dut_u (.clk(clk), .rst(rst), .ce(1'b1),
    .scl_in(scl), .sda_in(sda), .sda_out_q(sda_out), .sda_oe_q(sda_oe),
    .address_select_pin(sel), .load_strobe_n(strobe_n), .clear_outputs_n(clr_n),
    .channel_code_q(codes), .power_down_q(pd));
  odac_bus_master bus_u (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task chk_codes(input [15:0] exp);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) chk("code", exp, {6'h00, codes[k*W +: W]});
    end
  endtask
  task complete_run;
    begin
      $display("mismatches %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    chk_codes(16'h0000);
    chk("pd", 16'h00ff, {8'h00, pd});
    bus_u.frame(7'h48, 8'h01, 16'h0005, ack);
    chk("ack", 16'h0001, {15'h0, ack});
    chk("pd", 16'h0005, {8'h00, pd});
    bus_u.rd16(7'h48, rd, ack);
    chk("cfg", 16'h0005, rd);
    chk("sda_out", 16'h0000, {15'h0, sda_out});
    bus_u.frame(7'h48, 8'h01, 16'h0100, ack);
    chk("pd", 16'h00ff, {8'h00, pd});
    for (i = 0; i < 8; i = i + 1) begin
      w = 16'h0f00 + i * 16'h0014;
      bus_u.frame(7'h48, 8'h08 + i, w, ack);
      chk("code", {6'h00, w[11:2]}, {6'h00, codes[i*W +: W]});
    end
    @(posedge clk) #1 strobe_n = 1'b1;
    bus_u.frame(7'h48, 8'h09, 16'h0abc, ack);
    bus_u.frame(7'h48, 8'h0b, 16'h0123, ack);
    chk("code", 16'h03c5, {6'h00, codes[W +: W]});
    @(posedge clk) #1 strobe_n = 1'b0;
    repeat (10) @(posedge clk);
    chk("code", 16'h02af, {6'h00, codes[W +: W]});
    chk("code", 16'h0048, {6'h00, codes[3*W +: W]});
    bus_u.frame(7'h48, 8'h02, 16'h0000, ack);
    bus_u.rd16(7'h48, rd, ack);
    chk("ack", 16'h0001, {15'h0, ack});
    chk("id", {10'h000, ID}, {10'h000, rd[11:6]});
    bus_u.frame(7'h49, 8'h08, 16'h0fff, ack);
    chk("ack", 16'h0000, {15'h0, ack});
    @(posedge clk) #1 sel = 1'b1;
    bus_u.frame(7'h49, 8'h01, 16'h0100, ack);
    chk("ack", 16'h0001, {15'h0, ack});
    @(posedge clk) #1 sel = 1'b0;
    bus_u.rd16(7'h47, rd, ack);
    chk("ack", 16'h0000, {15'h0, ack});
    bus_u.frame(7'h47, 8'h03, 16'h0ffc, ack);
    chk_codes(16'h03ff);
    @(posedge clk) #1 clr_n = 1'b0;
    repeat (2) @(posedge clk);
    chk_codes(16'h0000);
    chk("pd", 16'h00ff, {8'h00, pd});
    @(posedge clk) #1 clr_n = 1'b1;
    bus_u.frame(7'h48, 8'h03, 16'h0ffc, ack);
    bus_u.frame(7'h48, 8'h01, 16'h0000, ack);
    bus_u.frame(7'h48, 8'h02, 16'h000a, ack);
    chk_codes(16'h0000);
    chk("pd", 16'h00ff, {8'h00, pd});
    bus_u.frame(7'h48, 8'h03, 16'h0ffc, ack);
    bus_u.frame(7'h48, 8'h01, 16'h0000, ack);
    bus_u.start;
    bus_u.wbyte(8'h00, ack);
    bus_u.wbyte(8'h06, ack);
    chk("ack", 16'h0001, {15'h0, ack});
    chk_codes(16'h0000);
    bus_u.stop;
    chk_codes(16'h0000);
    chk("pd", 16'h00ff, {8'h00, pd});
    complete_run;
  end
endmodule // octal_dac_update_control_bench
